// file: gpio_bank_pkg.sv
package gpio_bank_pkg;
  // Bus geometry: each register takes one word, byte address is four times the index.
  localparam int          ADDR_W = 16;
  localparam int          IDX_W  = 14;
  localparam int          DATA_W = 32;
  localparam int          P0_W   = 4;
  localparam int          P1_W   = 8;
  localparam int          P2_W   = 3;
  localparam int          P3_W   = 8;
  localparam int          PIN_W  = P0_W + P1_W + P2_W + P3_W;
  // Field positions of the ports inside the joined pin vector.
  localparam int          P0_LSB = 0;
  localparam int          P1_LSB = 4;
  localparam int          P2_LSB = 12;
  localparam int          P3_LSB = 15;
  // Register indices; data reads return pins, latch views return the latch.
  localparam logic [13:0] IDX_P0_DATA  = 14'h1F70;
  localparam logic [13:0] IDX_P1_DATA  = 14'h1F71;
  localparam logic [13:0] IDX_P2_DATA  = 14'h1F72;
  localparam logic [13:0] IDX_P3_DATA  = 14'h1F73;
  localparam logic [13:0] IDX_P0_LATCH = 14'h1F74;
  localparam logic [13:0] IDX_P1_LATCH = 14'h1F75;
  localparam logic [13:0] IDX_P2_LATCH = 14'h1F76;
  localparam logic [13:0] IDX_P3_LATCH = 14'h1F77;
  localparam logic [13:0] IDX_P0_DIR   = 14'h1F78;
  localparam logic [13:0] IDX_P1_DIR   = 14'h1F79;
  localparam logic [13:0] IDX_P3_DIR   = 14'h1F7B;
  localparam logic [13:0] IDX_P0_OD    = 14'h1F80;
  localparam logic [13:0] IDX_P3_OD    = 14'h1F83;
  localparam logic [13:0] IDX_SYSCTL   = 14'h1F60;
  localparam logic [13:0] IDX_STATUS   = 14'h1F61;
  // Control and status bit positions.
  localparam int          KEEP_BIT = 0;
  localparam int          EXTI_BIT = 0;
  // Reset values and bus encodings.
  localparam logic [3:0]  P0_RST     = 4'h0;
  localparam logic [7:0]  P1_RST     = 8'h00;
  localparam logic [2:0]  P2_RST     = 3'h7;
  localparam logic [7:0]  P3_RST     = 8'h00;
  localparam logic [3:0]  P0_DIR_RST = 4'h0;
  localparam logic [7:0]  P1_DIR_RST = 8'h00;
  localparam logic [7:0]  P3_DIR_RST = 8'h00;
  localparam logic [3:0]  P0_OD_RST  = 4'h0;
  localparam logic [7:0]  P3_OD_RST  = 8'h00;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;
endpackage

// file: gpio_bank.sv
`timescale 1ns/100ps
// Overview of operation
// - Output latches hold written value until rewritten.
// - Input reads return live pin level, uncaptured.
// - Pins sampled at read address phase.
// - Latches take written data at data phase end.
// - Read-modify-write reads return output latch contents.
// - All other port data reads return the pin level.
// - Port 0 direction resets to input.
// - Port 0 latch resets to zero.
// - Port 0 open-drain select resets to push-pull.
// - Port 1 direction and latch reset zero.
// - Port 2 latch resets to all ones.
// - Falling edge on port 2 bit 0 sets latch.
// - Port 2 bit 0 floats in stop mode.
// - Port 2 upper read bits read zero.
// - Port 2 modify reads latch, others pin.
// - Port 3 direction resets to input.
// - Port 3 latch resets to zero.
// - Port 3 open-drain select, one means open-drain.
// - Open-drain modify reads latch, others pin.
module gpio_bank (
  input  wire logic                            hclk,       // System clock.
  input  wire logic                            hresetn,    // Asynchronous reset, low.
  input  wire logic                            hsel,       // Slave select.
  input  wire logic [gpio_bank_pkg::ADDR_W-1:0] haddr,     // Byte address.
  input  wire logic [1:0]                      htrans,     // Transfer type.
  input  wire logic                            hwrite,     // Write when high.
  input  wire logic [2:0]                      hsize,      // Transfer size.
  input  wire logic [gpio_bank_pkg::DATA_W-1:0] hwdata,    // Write data.
  input  wire logic                            hready,     // Bus ready in.
  output logic                                 hreadyout,  // Always ready.
  output logic [1:0]                           hresp,      // Always OKAY.
  output logic [gpio_bank_pkg::DATA_W-1:0]     hrdata,     // Read data.
  input  wire logic                            stop_mode,  // Core is in stop mode.
  input  wire logic [gpio_bank_pkg::P0_W-1:0]  p0_in,      // Port 0 pin levels.
  output logic [gpio_bank_pkg::P0_W-1:0]       p0_out,     // Port 0 drive value.
  output logic [gpio_bank_pkg::P0_W-1:0]       p0_oe,      // Port 0 drive enable.
  input  wire logic [gpio_bank_pkg::P1_W-1:0]  p1_in,      // Port 1 pin levels.
  output logic [gpio_bank_pkg::P1_W-1:0]       p1_out,     // Port 1 drive value.
  output logic [gpio_bank_pkg::P1_W-1:0]       p1_oe,      // Port 1 drive enable.
  input  wire logic [gpio_bank_pkg::P2_W-1:0]  p2_in,      // Port 2 pin levels.
  output logic [gpio_bank_pkg::P2_W-1:0]       p2_out,     // Port 2 drive value.
  output logic [gpio_bank_pkg::P2_W-1:0]       p2_oe,      // Port 2 drive enable.
  input  wire logic [gpio_bank_pkg::P3_W-1:0]  p3_in,      // Port 3 pin levels.
  output logic [gpio_bank_pkg::P3_W-1:0]       p3_out,     // Port 3 drive value.
  output logic [gpio_bank_pkg::P3_W-1:0]       p3_oe,      // Port 3 drive enable.
  output logic                                 ext_int_flag // Interrupt latch of bit 0.
);
  import gpio_bank_pkg::*;

  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin_level;
  logic [PIN_W-1:0] next_pin_level;
  logic [P0_W-1:0]  port0_output_latch;
  logic [P1_W-1:0]  port1_output_latch;
  logic [P2_W-1:0]  port2_output_latch;
  logic [P3_W-1:0]  port3_output_latch;
  logic [P0_W-1:0]  port0_direction_reg;
  logic [P1_W-1:0]  port1_direction_reg;
  logic [P3_W-1:0]  port3_direction_reg;
  logic [P0_W-1:0]  port0_opendrain_select;
  logic [P3_W-1:0]  port3_opendrain_select;
  logic             stop_output_keep;
  logic             p2_bit0_prev;
  logic             fall_edge;
  logic             addr_take;
  logic             wr_pend;
  logic [IDX_W-1:0] addr_idx;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] next_rdata;
  logic             float_all;
  logic [7:0]       p0_en_full;

  // The index arithmetic assumes word-aligned registers fit the address bus.
  if (ADDR_W != IDX_W + 2) begin : bad_geometry
    $error("gpio_bank: address width must be index width plus two");
  end

  // True when the pending write in its data phase targets the given register.
  function automatic logic wr_hit(input logic pend, input logic [13:0] idx,
                                  input logic [13:0] reg_idx);
    wr_hit = pend && (idx == reg_idx);
  endfunction

  // Push-pull or open-drain enable: open-drain drives only a low level.
  function automatic logic [7:0] drive_en(input logic [7:0] dir, input logic [7:0] od,
                                          input logic [7:0] lat);
    drive_en = dir & ~(od & lat);
  endfunction

  // The slave never inserts wait states and never reports an error.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx  = haddr[ADDR_W-1:2];

  // Three-stage pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {p3_in, p2_in, p1_in, p0_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin change counts only once stages two and three agree.
  always_comb begin
    next_pin_level = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_level);
  end

  // Live pin image with no software capture latch behind it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level <= '0;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  // Write address phase is held for the following data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_idx  <= addr_idx;
    end
  end

  // Port 0 latch; data and latch views both write it at data phase end.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port0_output_latch <= P0_RST;
    end else if (wr_hit(wr_pend, wr_idx, IDX_P0_DATA) ||
                 wr_hit(wr_pend, wr_idx, IDX_P0_LATCH)) begin
      port0_output_latch <= hwdata[P0_W-1:0];
    end
  end

  // Port 1 latch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port1_output_latch <= P1_RST;
    end else if (wr_hit(wr_pend, wr_idx, IDX_P1_DATA) ||
                 wr_hit(wr_pend, wr_idx, IDX_P1_LATCH)) begin
      port1_output_latch <= hwdata[P1_W-1:0];
    end
  end

  // Port 2 latch starts high so its pins begin as inputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port2_output_latch <= P2_RST;
    end else if (wr_hit(wr_pend, wr_idx, IDX_P2_DATA) ||
                 wr_hit(wr_pend, wr_idx, IDX_P2_LATCH)) begin
      port2_output_latch <= hwdata[P2_W-1:0];
    end
  end

  // Port 3 latch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port3_output_latch <= P3_RST;
    end else if (wr_hit(wr_pend, wr_idx, IDX_P3_DATA) ||
                 wr_hit(wr_pend, wr_idx, IDX_P3_LATCH)) begin
      port3_output_latch <= hwdata[P3_W-1:0];
    end
  end

  // Direction registers, all inputs after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port0_direction_reg <= P0_DIR_RST;
      port1_direction_reg <= P1_DIR_RST;
      port3_direction_reg <= P3_DIR_RST;
    end else begin
      if (wr_hit(wr_pend, wr_idx, IDX_P0_DIR)) begin
        port0_direction_reg <= hwdata[P0_W-1:0];
      end
      if (wr_hit(wr_pend, wr_idx, IDX_P1_DIR)) begin
        port1_direction_reg <= hwdata[P1_W-1:0];
      end
      if (wr_hit(wr_pend, wr_idx, IDX_P3_DIR)) begin
        port3_direction_reg <= hwdata[P3_W-1:0];
      end
    end
  end

  // Open-drain selects, push-pull after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port0_opendrain_select <= P0_OD_RST;
      port3_opendrain_select <= P3_OD_RST;
    end else begin
      if (wr_hit(wr_pend, wr_idx, IDX_P0_OD)) begin
        port0_opendrain_select <= hwdata[P0_W-1:0];
      end
      if (wr_hit(wr_pend, wr_idx, IDX_P3_OD)) begin
        port3_opendrain_select <= hwdata[P3_W-1:0];
      end
    end
  end

  // System control bit that keeps outputs other than port 2 bit 0 driven during stop mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_output_keep <= 1'b0;
    end else if (wr_hit(wr_pend, wr_idx, IDX_SYSCTL)) begin
      stop_output_keep <= hwdata[KEEP_BIT];
    end
  end

  // A falling edge on port 2 bit 0, driven or external, sets the latch.
  assign fall_edge = p2_bit0_prev && !pin_level[P2_LSB];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p2_bit0_prev <= 1'b0;
      ext_int_flag <= 1'b0;
    end else begin
      p2_bit0_prev <= pin_level[P2_LSB];
      if (fall_edge) begin
        ext_int_flag <= 1'b1;
      end else if (wr_hit(wr_pend, wr_idx, IDX_STATUS) && hwdata[EXTI_BIT]) begin
        ext_int_flag <= 1'b0;
      end
    end
  end

  // Read mux: data indices give pins, latch indices give the latch.
  always_comb begin
    next_rdata = '0;
    unique case (addr_idx)
      IDX_P0_DATA:  next_rdata[P0_W-1:0] = next_pin_level[P0_LSB +: P0_W];
      IDX_P1_DATA:  next_rdata[P1_W-1:0] = next_pin_level[P1_LSB +: P1_W];
      IDX_P2_DATA:  next_rdata[P2_W-1:0] = next_pin_level[P2_LSB +: P2_W];
      IDX_P3_DATA:  next_rdata[P3_W-1:0] = next_pin_level[P3_LSB +: P3_W];
      IDX_P0_LATCH: next_rdata[P0_W-1:0] = port0_output_latch;
      IDX_P1_LATCH: next_rdata[P1_W-1:0] = port1_output_latch;
      IDX_P2_LATCH: next_rdata[P2_W-1:0] = port2_output_latch;
      IDX_P3_LATCH: next_rdata[P3_W-1:0] = port3_output_latch;
      IDX_P0_DIR:   next_rdata[P0_W-1:0] = port0_direction_reg;
      IDX_P1_DIR:   next_rdata[P1_W-1:0] = port1_direction_reg;
      IDX_P3_DIR:   next_rdata[P3_W-1:0] = port3_direction_reg;
      IDX_P0_OD:    next_rdata[P0_W-1:0] = port0_opendrain_select;
      IDX_P3_OD:    next_rdata[P3_W-1:0] = port3_opendrain_select;
      IDX_SYSCTL:   next_rdata[KEEP_BIT] = stop_output_keep;
      IDX_STATUS:   next_rdata[EXTI_BIT] = ext_int_flag;
      default:      next_rdata = '0;
    endcase
  end

  // Read data is captured at the address phase edge; port 2 upper bits read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Drive values come straight from the latches.
  assign p0_out = port0_output_latch;
  assign p1_out = port1_output_latch;
  assign p2_out = port2_output_latch;
  assign p3_out = port3_output_latch;

  // Stop mode floats every pin unless the keep bit is set.
  assign float_all = stop_mode && !stop_output_keep;

  // Port 0 is padded to the byte width of the shared enable function.
  assign p0_en_full = drive_en({4'h0, port0_direction_reg}, {4'h0, port0_opendrain_select},
                               {4'h0, port0_output_latch});

  // Enables: direction gates the driver on ports 0, 1 and 3; open-drain drives only low.
  always_comb begin
    p0_oe = float_all ? '0 : p0_en_full[P0_W-1:0];
    p1_oe = float_all ? '0 : port1_direction_reg;
    p3_oe = float_all ? '0 : drive_en(port3_direction_reg, port3_opendrain_select,
                                      port3_output_latch);
    // Port 2 is a sink-only port: a latch of one releases the pin.
    p2_oe = float_all ? '0 : ~port2_output_latch;
    if (stop_mode) begin
      p2_oe[0] = 1'b0;
    end
  end

  // Read and write phases used by the checks below.
  sequence rd_phase(logic [13:0] idx);
    addr_take && !hwrite && (addr_idx == idx);
  endsequence

  sequence wr_phase(logic [13:0] idx);
    addr_take && hwrite && (addr_idx == idx) ##1 1'b1;
  endsequence

  pin_sample_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_phase(IDX_P1_DATA) |=> hrdata[7:0] == $past(next_pin_level[P1_LSB +: P1_W]))
    else $error("port 1 read did not return the sampled pins");

  latch_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_phase(IDX_P3_DATA) |=> port3_output_latch == $past(hwdata[7:0]))
    else $error("port 3 latch missed its write");

  latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && (wr_idx == IDX_P1_DATA || wr_idx == IDX_P1_LATCH))
    |=> $stable(port1_output_latch))
    else $error("port 1 latch changed without a write");

  rmw_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_phase(IDX_P0_LATCH) |=> hrdata == {28'h0, $past(port0_output_latch)})
    else $error("latch view did not return the latch");

  p2_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_phase(IDX_P2_DATA) |=> hrdata[31:3] == 29'h0)
    else $error("port 2 upper bits not zero");

  stop_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_mode |-> !p2_oe[0])
    else $error("port 2 bit 0 driven in stop mode");

  dir_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !stop_mode |-> p1_oe == port1_direction_reg)
    else $error("port 1 enable differs from direction");

  od_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    port3_opendrain_select[0] && port3_output_latch[0] |-> !p3_oe[0])
    else $error("open-drain pin driven high");

  edge_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_level[P2_LSB] ##1 !pin_level[P2_LSB] |=> ext_int_flag)
    else $error("falling edge did not set the latch");

  init_state_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> port2_output_latch == P2_RST && port0_output_latch == P0_RST)
    else $error("latch reset values wrong");

  p0_reset_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> port0_direction_reg == P0_DIR_RST &&
                       port0_opendrain_select == P0_OD_RST)
    else $error("port 0 control reset values wrong");

  p1_reset_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> port1_output_latch == P1_RST && port1_direction_reg == P1_DIR_RST)
    else $error("port 1 reset values wrong");

  p3_reset_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> port3_output_latch == P3_RST && port3_direction_reg == P3_DIR_RST &&
                       port3_opendrain_select == P3_OD_RST)
    else $error("port 3 reset values wrong");

  p2_latch_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_phase(IDX_P2_LATCH) |=> hrdata == {29'h0, $past(port2_output_latch)})
    else $error("port 2 latch view did not return the latch");

  p3_latch_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_phase(IDX_P3_LATCH) |=> hrdata == {24'h0, $past(port3_output_latch)})
    else $error("port 3 latch view did not return the latch");

  stop_all_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_mode && !stop_output_keep |-> p0_oe == '0 && p1_oe == '0 &&
                                       p2_oe == '0 && p3_oe == '0)
    else $error("pin driven in stop mode without the keep bit");

  p0_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_phase(IDX_P0_DATA) |=> port0_output_latch == $past(hwdata[P0_W-1:0]))
    else $error("port 0 latch missed its write");
endmodule

// file: board_pins.sv
`timescale 1ns/100ps
module board_pins #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] o,   // Value the port drives.
  input  wire logic [W-1:0] oe,  // Port drive enable.
  input  wire logic [W-1:0] bv,  // Value the board drives.
  input  wire logic [W-1:0] be,  // Board drive enable.
  output logic      [W-1:0] lvl  // Resolved pin level.
);
  // A pin follows the port while it drives, else the board, else the board pull-up.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i])
        lvl[i] = o[i];
      else if (be[i])
        lvl[i] = bv[i];
      else
        lvl[i] = 1'b1;
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import gpio_bank_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [13:0] idx;
    logic [31:0] data;
  } row_s;
  logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic            stop_mode = 1'b0;
  logic [15:0]     haddr = 16'h0;
  logic [1:0]      htrans = 2'h0, hresp;
  logic [2:0]      hsize = 3'h2;
  logic [31:0]     hwdata = 32'h0, hrdata, rd;
  wire             hready;
  logic            ext_int_flag;
  logic [P0_W-1:0] p0_in, p0_out, p0_oe, b0v = 4'h0, b0e = 4'h0;
  logic [P1_W-1:0] p1_in, p1_out, p1_oe, b1v = 8'h00, b1e = 8'h00;
  logic [P2_W-1:0] p2_in, p2_out, p2_oe, b2v = 3'h0, b2e = 3'h0;
  logic [P3_W-1:0] p3_in, p3_out, p3_oe, b3v = 8'h00, b3e = 8'h00;
  int              num_errors = 0;
  int              checked = 0;
  // Ordinary register rows first, reset value rows from index 20 on.
  row_s rows [31] = '{
    '{1'b1, IDX_P0_DATA, 32'hFFFFFFFA}, '{1'b0, IDX_P0_LATCH, 32'hA},
    '{1'b1, IDX_P1_DATA, 32'h5A}, '{1'b0, IDX_P1_LATCH, 32'h5A},
    '{1'b1, IDX_P2_DATA, 32'h2}, '{1'b0, IDX_P2_LATCH, 32'h2},
    '{1'b1, IDX_P3_DATA, 32'hC3}, '{1'b0, IDX_P3_LATCH, 32'hC3},
    '{1'b1, IDX_P0_DIR, 32'hF}, '{1'b0, IDX_P0_DIR, 32'hF},
    '{1'b1, IDX_P1_DIR, 32'hFF}, '{1'b0, IDX_P1_DIR, 32'hFF},
    '{1'b1, IDX_P3_DIR, 32'hFF}, '{1'b0, IDX_P3_DIR, 32'hFF},
    '{1'b1, IDX_P0_OD, 32'hA}, '{1'b0, IDX_P0_OD, 32'hA},
    '{1'b1, IDX_P3_OD, 32'h0F}, '{1'b0, IDX_P3_OD, 32'h0F},
    '{1'b1, 14'h1F7A, 32'hFF}, '{1'b0, 14'h1F7A, 32'h0},
    '{1'b0, IDX_P0_LATCH, 32'h0}, '{1'b0, IDX_P1_LATCH, 32'h0},
    '{1'b0, IDX_P2_LATCH, 32'h7}, '{1'b0, IDX_P3_LATCH, 32'h0},
    '{1'b0, IDX_P0_DIR, 32'h0}, '{1'b0, IDX_P1_DIR, 32'h0},
    '{1'b0, IDX_P3_DIR, 32'h0}, '{1'b0, IDX_P0_OD, 32'h0},
    '{1'b0, IDX_P3_OD, 32'h0}, '{1'b0, IDX_SYSCTL, 32'h0},
    '{1'b0, IDX_STATUS, 32'h0}
  };

  // Clock of 10 ns period.
  always #5 hclk = ~hclk;

  gpio_bank DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in), .p1_out(p1_out),
    .p1_oe(p1_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in),
    .p3_out(p3_out), .p3_oe(p3_oe), .ext_int_flag(ext_int_flag)
  );
  // The board side of each port.
  board_pins #(.W(P0_W)) bp0 (.o(p0_out), .oe(p0_oe), .bv(b0v), .be(b0e), .lvl(p0_in));
  board_pins #(.W(P1_W)) bp1 (.o(p1_out), .oe(p1_oe), .bv(b1v), .be(b1e), .lvl(p1_in));
  board_pins #(.W(P2_W)) bp2 (.o(p2_out), .oe(p2_oe), .bv(b2v), .be(b2e), .lvl(p2_in));
  board_pins #(.W(P3_W)) bp3 (.o(p3_out), .oe(p3_oe), .bv(b3v), .be(b3e), .lvl(p3_in));

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Waits for an edge at which the bus is ready, under a bound.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: bus never ready", $time);
      stop_test();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdv);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    wait_ready();
    rdv = hrdata;
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp, input string what);
    xfer(1'b0, idx, 32'h0, rd);
    check(rd, exp, what);
  endtask

  // Runs a range of table rows.
  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      xfer(rows[i].wr, rows[i].idx, rows[i].data, rd);
      if (!rows[i].wr)
        check(rd, rows[i].data, "register readback");
    end
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    run_rows(0, 19);
    #1;
    check(32'(p0_out), 32'hA, "port 0 drive");
    check(32'(p0_oe), 32'h5, "port 0 enable");
    check(32'(p3_oe), 32'hFC, "port 3 enable");
    check(32'(p1_out), 32'h5A, "port 1 latch held");
    check(32'(p2_oe), 32'h5, "port 2 enable");
    check(32'(hresp), 32'(HRESP_OKAY), "bus response");
    // The board pulls released open-drain bits port 0 bit 1 and port 3 bit 0 low; the others pull up.
    @(posedge hclk);
    b0e <= 4'h2;
    b3e <= 8'h01;
    repeat (6) @(posedge hclk);
    rdchk(IDX_P0_DATA, 32'h8, "port 0 pins");
    rdchk(IDX_P0_LATCH, 32'hA, "port 0 latch");
    rdchk(IDX_P1_DATA, 32'h5A, "port 1 pins");
    rdchk(IDX_P3_DATA, 32'hC2, "port 3 pins");
    rdchk(IDX_P3_LATCH, 32'hC3, "port 3 latch");
    // Port 2 as input: the latch is left high first.
    xfer(1'b1, IDX_P2_DATA, 32'h7, rd);
    b2e <= 3'h7;
    b2v <= 3'h2;
    repeat (6) @(posedge hclk);
    rdchk(IDX_P2_DATA, 32'h2, "port 2 pins");
    rdchk(IDX_P2_LATCH, 32'h7, "port 2 latch");
    b2v <= 3'h5;
    repeat (6) @(posedge hclk);
    rdchk(IDX_P2_DATA, 32'h5, "port 2 live pins");
    // Clear the flag, then make the port itself pull bit 0 low.
    xfer(1'b1, IDX_STATUS, 32'h1, rd);
    rdchk(IDX_STATUS, 32'h0, "flag cleared");
    b2e <= 3'h6;
    xfer(1'b1, IDX_P2_DATA, 32'h6, rd);
    repeat (6) @(posedge hclk);
    #1;
    check(32'(ext_int_flag), 32'h1, "flag on output fall");
    rdchk(IDX_STATUS, 32'h1, "flag status");
    // Stop mode with and without the keep bit.
    xfer(1'b1, IDX_SYSCTL, 32'h1, rd);
    stop_mode <= 1'b1;
    @(posedge hclk);
    #1;
    check(32'(p2_oe), 32'h0, "stop pin floats");
    check(32'(p1_oe), 32'hFF, "kept drive");
    @(posedge hclk);
    stop_mode <= 1'b0;
    xfer(1'b1, IDX_SYSCTL, 32'h0, rd);
    #1;
    check(32'(p2_oe), 32'h1, "stop pin driven");
    @(posedge hclk);
    stop_mode <= 1'b1;
    @(posedge hclk);
    #1;
    check(32'(p1_oe), 32'h0, "stop floats all");
    // The port 3 latch is written high through its latch view and checked at the drive value.
    xfer(1'b1, IDX_P3_LATCH, 32'hFF, rd);
    #1;
    check(32'(p3_out), 32'hFF, "port 3 latch high");
    // Second reset in mid-run.
    @(posedge hclk);
    stop_mode <= 1'b0;
    hresetn   <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
    check(32'(p0_out), 32'h0, "port 0 reset");
    check(32'(p2_out), 32'h7, "port 2 reset");
    check(32'(p3_out), 32'h0, "port 3 reset");
    check(32'(p1_oe), 32'h0, "port 1 input");
    check(32'(p3_oe), 32'h0, "port 3 input");
    check(32'(ext_int_flag), 32'h0, "flag reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    run_rows(20, 30);
    stop_test();
  end

  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge hclk);
    $display("MISMATCH at %0t: watchdog expired", $time);
    num_errors++;
    stop_test();
  end
endmodule
